// ### pocc_asserts.sv
// port assertions for the pressure output command block
`timescale 1ns/1ps
module pocc_asserts (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic tx_space,
    input wire pocc_pkg::pocc_reading_type reading,
    input wire pocc_pkg::pocc_analog_type analog,
    input wire logic sys_reset_req
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [5:0] csum;
    logic is_bin;
    // only the low six bits of each character reach the low six sum bits
    assign csum = reading.bin_chars[45:40] + reading.bin_chars[37:32]
        + reading.bin_chars[29:24] + reading.bin_chars[21:16]
        + reading.bin_chars[13:8] + reading.bin_chars[5:0];
    assign is_bin = reading.valid && reading.kind == pocc_pkg::RD_BINARY;
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_done;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer: assert property (s_req |=> s_done)
        else $error("bus answer not one cycle long");
    a_offset_clamp: assert property (analog.low_pct <= 7'h63)
        else $error("analog offset above 99");
    a_span_limit: assert property
        ((8'(analog.low_pct) + 8'(analog.span_pct)) <= 8'h64)
        else $error("offset plus span above full output");
    a_space_gate: assert property (reading.valid |-> $past(tx_space))
        else $error("reading sent without buffer space");
    a_fault_zero: assert property
        (reading.valid && reading.kind == pocc_pkg::RD_FAULT
        |-> reading.magnitude == 17'h00000)
        else $error("fault reading not zero");
    a_check_sum: assert property
        (is_bin && reading.bin_chars[7:0] != 8'h00 |-> csum == 6'h00)
        else $error("binary checksum wrong");
    a_dog_restore: assert property
        (sys_reset_req |=> !sys_reset_req && analog.low_pct == 7'h00
        && analog.span_pct == 7'h64)
        else $error("watchdog reset did not restore analog");
    a_bin_header: assert property
        (is_bin |-> reading.bin_chars[47:46] == 2'h0
        || reading.bin_chars[47:40] == pocc_pkg::HDR_POS
        || reading.bin_chars[47:40] == pocc_pkg::HDR_NEG)
        else $error("binary header not a header character");
endmodule : pocc_asserts

bind pocc_command_control pocc_asserts chk_u (.*);

// ### pocc_bin_encoder.sv
// binary reading encoder: header, four data characters and checksum
`timescale 1ns/1ps
module pocc_bin_encoder (
    input wire logic [6:0] addr,
    input wire logic sign,
    input wire logic [16:0] magnitude,
    input wire pocc_pkg::pocc_fmt_type fmt,
    input wire logic checksum_en,
    output logic [47:0] chars
);

    function automatic logic [7:0] char6(input logic [5:0] v);
        return pocc_pkg::CHAR_BASE | {2'h0, v};
    endfunction : char6

    logic [23:0] bits;
    logic [7:0] header;
    logic [7:0] d0, d1, d2, d3, ck;
    logic [9:0] sum;
    logic [5:0] ck6;

    always_comb
    begin
        // signed form trades the top magnitude bit for an explicit sign
        if (fmt == pocc_pkg::FMT_SIGNED)
            bits = {addr, sign, magnitude[15:0]};
        else
            bits = {addr, magnitude};
        if (fmt == pocc_pkg::FMT_EXTENDED)
            header = sign ? pocc_pkg::HDR_NEG : pocc_pkg::HDR_POS;
        else
            header = pocc_pkg::HDR_STD;
        d0 = char6(bits[23:18]);
        d1 = char6(bits[17:12]);
        d2 = char6(bits[11:6]);
        d3 = char6(bits[5:0]);
        sum = 10'(header) + 10'(d0) + 10'(d1) + 10'(d2) + 10'(d3);
        ck6 = 6'(6'h00 - sum[5:0]);
        ck = checksum_en ? char6(ck6) : 8'h00;
        chars = {header, d0, d1, d2, d3, ck};
    end

endmodule : pocc_bin_encoder

// ### pocc_command_control.sv
// register front end, reading dispatch and watchdog of the command block
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - offset 0..99 percent, default 0, readable
// - offset writes above 99 clamp to 99
// - offset never alters serial reading values
// - malformed offset sets error, keeps old value
// - offset applies only with window scaling enabled
// - offset shrinks span to keep 5V limit
// - changes-only sends changed readings; first always
// - checksum makes low six sum bits zero
// - extended: 7-bit address, 17-bit magnitude, header sign
// - signed: address, sign, 16 bits; four digits above
// - header-removed text starts with the sign
// - watchdog resets everything after 50 ms stall; the bus wait state and read data are kept
// - watchdog refused with error unless averaging zero
// - date reads back, bang on parity error
// - group single request obeys changes-only setting
// - single during continuous sends one text reading
// - group single skips already read reading
// - send only with buffer space; a single request without space sets flag
// - no valid reading gives dotted no-data reply
// - temperature or parity fault gives bang zero
// - multidrop streams only with continuous option
// - status read clears; memory checksum needs two
module pocc_command_control #(
    parameter int WDOG_CYCLES = pocc_pkg::WDOG_CYCLES,
    parameter logic [23:0] PROD_DATE = 24'h010100 // arbitrary value
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire pocc_pkg::pocc_sample_type sample,
    input wire logic proc_alive,
    input wire logic temp_range_fault,
    input wire logic mem_parity_fault,
    input wire logic mem_checksum_err,
    input wire logic tx_space,
    output pocc_pkg::pocc_reading_type reading,
    output pocc_pkg::pocc_analog_type analog,
    output logic sys_reset_req
);

    localparam int WDW = 24;

    initial
    begin
        if (WDOG_CYCLES < 1 || WDOG_CYCLES >= (1 << WDW))
            $error("WDOG_CYCLES out of range");
    end

    localparam logic [WDW-1:0] WDOG_LAST = WDW'(WDOG_CYCLES - 1);

    typedef struct packed {
        logic waitreq;
        logic [31:0] readdata;
        logic [6:0] offset;
        logic [6:0] span;
        pocc_pkg::pocc_op_type op;
        logic [7:0] avg_count;
        logic scale_en;
        logic text_off;
        logic cont_tx;
        logic multidrop;
        logic [6:0] dev_num;
        logic cmd_err;
        logic temp_err;
        logic parity_err;
        logic memck_err;
        logic memck_half;
        logic no_space;
        pocc_pkg::pocc_cont_type cont_mode;
        logic suspended;
        logic first_pending;
        logic fresh;
        logic data_valid;
        logic sample_read;
        logic sent_sign;
        logic [16:0] sent_mag;
        logic cur_sign;
        logic [16:0] cur_mag;
        logic [WDW-1:0] wdog_cnt;
        logic sys_reset;
        pocc_pkg::pocc_reading_type reading;
        pocc_pkg::pocc_analog_type analog;
    } pocc_state_type;

    function automatic pocc_state_type reset_state();
        pocc_state_type r;
        r = '0;
        r.waitreq = 1'b1;
        r.offset = pocc_pkg::OFFSET_RESET;
        r.span = pocc_pkg::SPAN_FULL;
        r.analog.span_pct = pocc_pkg::SPAN_FULL;
        return r;
    endfunction : reset_state

    pocc_state_type s;
    pocc_state_type next_s;
    logic [47:0] bin_chars;

    pocc_bin_encoder u_enc (
        .addr(s.dev_num),
        .sign(s.cur_sign),
        .magnitude(s.cur_mag),
        .fmt(s.op.fmt),
        .checksum_en(s.op.checksum),
        .chars(bin_chars)
    );

    // builds one reading from the latest sample; offset is not consulted
    function automatic pocc_pkg::pocc_reading_type make_reading(
        input pocc_state_type st,
        input logic bin,
        input logic fault,
        input logic [47:0] chars
    );
        pocc_pkg::pocc_reading_type r;
        r = '0;
        r.valid = 1'b1;
        r.sign = st.cur_sign;
        r.magnitude = st.cur_mag;
        r.hdr_removed = !bin && st.op.fmt == pocc_pkg::FMT_REMOVED;
        r.fixed_sign = !bin && st.op.fmt == pocc_pkg::FMT_FIXED;
        r.four_digit = st.op.fmt == pocc_pkg::FMT_SIGNED &&
            st.cur_mag > pocc_pkg::SIGNED_FULL_COUNTS;
        if (!st.data_valid || (st.text_off && !bin))
        begin
            r.kind = pocc_pkg::RD_NODATA;
            r.magnitude = '0;
        end
        else if (fault)
        begin
            r.kind = pocc_pkg::RD_FAULT;
            r.magnitude = '0;
            r.sign = 1'b0;
        end
        else if (bin)
        begin
            r.kind = pocc_pkg::RD_BINARY;
            r.bin_chars = chars;
        end
        else
            r.kind = pocc_pkg::RD_TEXT;
        return r;
    endfunction : make_reading

    function automatic logic [6:0] clamp_pct(input logic [7:0] v,
        input logic [6:0] lim);
        return (v > {1'b0, lim}) ? lim : v[6:0];
    endfunction : clamp_pct

    always_comb
    begin
        logic req;
        logic wr;
        logic rd;
        logic fault;
        logic changed;
        logic emitted;
        logic [6:0] span_lim;
        logic [6:0] new_ofs;
        pocc_pkg::pocc_op_type new_op;
        pocc_pkg::pocc_cmd_type cmd;
        req = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        fault = 1'b0;
        changed = 1'b0;
        emitted = 1'b0;
        span_lim = '0;
        new_ofs = '0;
        new_op = '0;
        cmd = pocc_pkg::CMD_NONE;
        next_s = s;
        next_s.sys_reset = 1'b0;
        next_s.reading.valid = 1'b0;
        fault = temp_range_fault || mem_parity_fault;
        changed = s.cur_sign != s.sent_sign || s.cur_mag != s.sent_mag;

        // one wait cycle per access, then the answer edge
        req = avs_read || avs_write;
        next_s.waitreq = !(req && s.waitreq);
        wr = avs_write && !s.waitreq && avs_byteenable != 4'h0;
        rd = avs_read && !s.waitreq;
        if (avs_read && s.waitreq)
        begin
            unique case (avs_address)
                pocc_pkg::ADDR_OFFSET: next_s.readdata = {25'h0, s.offset};
                pocc_pkg::ADDR_SPAN: next_s.readdata = {25'h0, s.span};
                pocc_pkg::ADDR_RUN: next_s.readdata = {27'h0, s.op};
                pocc_pkg::ADDR_AVG: next_s.readdata = {24'h0, s.avg_count};
                pocc_pkg::ADDR_ANALOG:
                    next_s.readdata = {28'h0, s.multidrop, s.cont_tx,
                        s.text_off, s.scale_en};
                pocc_pkg::ADDR_STATUS:
                    next_s.readdata = {27'h0, s.no_space, s.memck_err,
                        s.parity_err, s.temp_err, s.cmd_err};
                pocc_pkg::ADDR_DATE:
                    next_s.readdata = {7'h0, mem_parity_fault,
                        PROD_DATE};
                pocc_pkg::ADDR_DEVNUM: next_s.readdata = {25'h0, s.dev_num};
                default: next_s.readdata = 32'h0;
            endcase
        end

        // status read clears; sets below win over this clear
        if (rd && avs_address == pocc_pkg::ADDR_STATUS)
        begin
            next_s.cmd_err = 1'b0;
            next_s.temp_err = 1'b0;
            next_s.parity_err = 1'b0;
            next_s.no_space = 1'b0;
            if (s.memck_half)
            begin
                next_s.memck_err = 1'b0;
                next_s.memck_half = 1'b0;
            end
            else if (s.memck_err)
                next_s.memck_half = 1'b1;
        end

        if (sample.valid)
        begin
            next_s.cur_sign = sample.sign;
            next_s.cur_mag = sample.magnitude;
            next_s.data_valid = 1'b1;
            next_s.sample_read = 1'b0;
            next_s.fresh = 1'b1;
        end

        if (wr)
        begin
            cmd = pocc_pkg::pocc_cmd_type'(avs_writedata[2:0]);
            unique case (avs_address)
                pocc_pkg::ADDR_OFFSET:
                begin
                    if (avs_writedata[pocc_pkg::OFS_BAD_BIT])
                        next_s.cmd_err = 1'b1;
                    else
                    begin
                        new_ofs = clamp_pct(avs_writedata[7:0],
                            pocc_pkg::OFFSET_MAX);
                        next_s.offset = new_ofs;
                        span_lim = 7'(pocc_pkg::SPAN_FULL - new_ofs);
                        if (s.span > span_lim)
                            next_s.span = span_lim;
                    end
                end
                pocc_pkg::ADDR_SPAN:
                begin
                    span_lim = 7'(pocc_pkg::SPAN_FULL - s.offset);
                    next_s.span = clamp_pct(avs_writedata[7:0],
                        span_lim);
                end
                pocc_pkg::ADDR_RUN:
                begin
                    new_op = avs_writedata[4:0];
                    if (new_op.wdog && !s.op.wdog && s.avg_count != 8'h00)
                    begin
                        new_op.wdog = 1'b0;
                        next_s.cmd_err = 1'b1;
                    end
                    next_s.op = new_op;
                end
                pocc_pkg::ADDR_AVG: next_s.avg_count = avs_writedata[7:0];
                pocc_pkg::ADDR_ANALOG:
                begin
                    next_s.scale_en = avs_writedata[pocc_pkg::AN_SCALE_BIT];
                    next_s.text_off =
                        avs_writedata[pocc_pkg::AN_TEXT_OFF_BIT];
                    next_s.cont_tx = avs_writedata[pocc_pkg::AN_CONT_TX_BIT];
                    next_s.multidrop =
                        avs_writedata[pocc_pkg::AN_MULTIDROP_BIT];
                end
                pocc_pkg::ADDR_DEVNUM:
                begin
                    next_s.dev_num = avs_writedata[6:0];
                    next_s.data_valid = 1'b0;
                end
                pocc_pkg::ADDR_COMMAND:
                begin
                    unique case (cmd)
                        pocc_pkg::CMD_SINGLE_TEXT,
                        pocc_pkg::CMD_SINGLE_BIN:
                        begin
                            if (avs_writedata[pocc_pkg::CMD_GROUP_BIT] &&
                                (s.sample_read ||
                                (s.op.changes_only && !changed)))
                                emitted = 1'b0;
                            else if (!tx_space)
                                next_s.no_space = 1'b1;
                            else
                            begin
                                // a request during streaming is always text
                                next_s.reading = make_reading(s,
                                    cmd == pocc_pkg::CMD_SINGLE_BIN &&
                                    s.cont_mode == pocc_pkg::CONT_IDLE,
                                    fault, bin_chars);
                                emitted = 1'b1;
                            end
                        end
                        pocc_pkg::CMD_CONT_TEXT, pocc_pkg::CMD_CONT_BIN:
                        begin
                            next_s.cont_mode =
                                (cmd == pocc_pkg::CMD_CONT_BIN) ?
                                pocc_pkg::CONT_BIN : pocc_pkg::CONT_TEXT;
                            next_s.suspended = 1'b0;
                            next_s.first_pending = 1'b1;
                        end
                        pocc_pkg::CMD_STOP:
                        begin
                            next_s.cont_mode = pocc_pkg::CONT_IDLE;
                            next_s.suspended = 1'b0;
                        end
                        pocc_pkg::CMD_SUSPEND: next_s.suspended = 1'b1;
                        pocc_pkg::CMD_INVALIDATE:
                            next_s.data_valid = 1'b0;
                        pocc_pkg::CMD_NONE: emitted = 1'b0;
                    endcase
                end
                default: emitted = 1'b0;
            endcase
        end

        // continuous stream; a single request takes this cycle first
        if (!emitted && s.cont_mode != pocc_pkg::CONT_IDLE &&
            !s.suspended && (s.first_pending || s.fresh))
        begin
            next_s.fresh = sample.valid;
            if (tx_space &&
                (s.first_pending || !s.op.changes_only || changed))
            begin
                next_s.reading = make_reading(s,
                    s.cont_mode == pocc_pkg::CONT_BIN, fault, bin_chars);
                emitted = 1'b1;
                next_s.first_pending = 1'b0;
                if (s.multidrop && !s.cont_tx)
                    next_s.cont_mode = pocc_pkg::CONT_IDLE;
            end
        end
        if (emitted)
        begin
            next_s.sample_read = 1'b1;
            next_s.sent_sign = s.cur_sign;
            next_s.sent_mag = s.cur_mag;
        end

        // sticky sets win over the status-read clear
        if (temp_range_fault)
            next_s.temp_err = 1'b1;
        if (mem_parity_fault)
            next_s.parity_err = 1'b1;
        if (mem_checksum_err)
        begin
            next_s.memck_err = 1'b1;
            next_s.memck_half = 1'b0;
        end

        next_s.analog.low_pct = s.scale_en ? s.offset : 7'h00;
        next_s.analog.span_pct = s.scale_en ? s.span :
            pocc_pkg::SPAN_FULL;

        // watchdog: a missing heartbeat for the full time resets all but the bus wait state and read data
        if (!s.op.wdog || proc_alive)
            next_s.wdog_cnt = '0;
        else if (s.wdog_cnt == WDOG_LAST)
        begin
            next_s = reset_state();
            next_s.waitreq = !(req && s.waitreq);
            next_s.readdata = s.readdata;
            next_s.sys_reset = 1'b1;
        end
        else
            next_s.wdog_cnt = WDW'(s.wdog_cnt + 1'b1);
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            s <= reset_state();
        else
            s <= next_s;
    end

    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.waitreq;
    assign reading = s.reading;
    assign analog = s.analog;
    assign sys_reset_req = s.sys_reset;

endmodule : pocc_command_control

// ### pocc_command_control_tb_top.sv
// self-checking bench of the pressure output command block
`timescale 1ns/1ps
module pocc_command_control_tb_top;
    localparam logic [7:0] A_OF = pocc_pkg::ADDR_OFFSET;
    localparam logic [7:0] A_RN = pocc_pkg::ADDR_RUN;
    localparam logic [7:0] A_ST = pocc_pkg::ADDR_STATUS;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    pocc_pkg::pocc_sample_type sample = '0;
    logic proc_alive = 1'b1;
    logic temp_range_fault = 1'b0;
    logic mem_parity_fault = 1'b0;
    logic mem_checksum_err = 1'b0;
    logic stall = 1'b0;
    logic tx_space;
    logic sys_reset_req;
    pocc_pkg::pocc_reading_type reading;
    pocc_pkg::pocc_reading_type last;
    pocc_pkg::pocc_analog_type analog;
    int count;
    int ec = 0;
    int fails = 0;
    int comparisons = 0;
    logic [31:0] q;
    always #5 core_clk = ~core_clk;
    pocc_command_control #(.WDOG_CYCLES(20), .PROD_DATE(24'h123456)) dut_u (
        .*);
    pocc_host_model host_u (.*);
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        logic wt;
        int n;
        wt = 1'b1;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // look before each edge; the edge after a low wait is the answer
        while (wt)
        begin
            @(negedge core_clk);
            wt = avs_waitrequest !== 1'b0;
            q = avs_readdata;
            @(posedge core_clk);
            if (++n > 50)
            begin
                fails++;
                print_verdict();
            end
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rd(input string n, input logic [7:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rd
    // margin for the sink to count the reading
    task automatic cmd(input logic [31:0] c, input int more);
        bus(1'b1, pocc_pkg::ADDR_COMMAND, c);
        repeat (3) @(posedge core_clk);
        ec += more;
        chk("reading count", 32'(ec), 32'(count));
    endtask : cmd
    task automatic smp(input logic [16:0] m, input int more);
        sample <= '{1'b1, 1'b0, m};
        @(posedge core_clk);
        sample <= '0;
        repeat (3) @(posedge core_clk);
        ec += more;
        chk("stream count", 32'(ec), 32'(count));
    endtask : smp
    task automatic knd(input pocc_pkg::pocc_rd_kind_type k);
        chk("reading kind", 32'(k), 32'(last.kind));
    endtask : knd
    task automatic t_regs();
        mem_checksum_err <= 1'b1;
        @(posedge core_clk);
        mem_checksum_err <= 1'b0;
        rd("status memck", A_ST, 32'h8);
        rd("status again", A_ST, 32'h8);
        rd("status clear", A_ST, 32'h0);
        rd("offset reset", A_OF, 32'h0);
        rd("span reset", pocc_pkg::ADDR_SPAN, 32'h64);
        rd("run reset", A_RN, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        rd("date", pocc_pkg::ADDR_DATE, 32'h00123456);
        mem_parity_fault <= 1'b1;
        rd("date bang", pocc_pkg::ADDR_DATE, 32'h01123456);
        mem_parity_fault <= 1'b0;
        $display("register test done");
    endtask : t_regs
    task automatic t_offset();
        bus(1'b1, A_OF, 32'h14);
        rd("offset 20", A_OF, 32'h14);
        @(negedge core_clk);
        chk("analog unscaled", 32'h0, 32'(analog.low_pct));
        bus(1'b1, pocc_pkg::ADDR_ANALOG, 32'h1);
        repeat (2) @(negedge core_clk);
        chk("analog scaled", 32'h14, 32'(analog.low_pct));
        bus(1'b1, A_OF, 32'hC8);
        rd("offset clamp", A_OF, 32'h63);
        rd("span shrunk", pocc_pkg::ADDR_SPAN, 32'h1);
        bus(1'b1, A_OF, 32'h8005);
        rd("offset kept", A_OF, 32'h63);
        // parity flag left from the date test is still pending
        rd("error set", A_ST, 32'h5);
        rd("error cleared", A_ST, 32'h0);
        $display("offset test done");
    endtask : t_offset
    task automatic t_single();
        cmd(32'h1, 1);
        knd(pocc_pkg::RD_NODATA);
        smp(17'h01234, 0);
        cmd(32'h1, 1);
        knd(pocc_pkg::RD_TEXT);
        chk("text value", 32'h1234, 32'(last.magnitude));
        temp_range_fault <= 1'b1;
        cmd(32'h1, 1);
        knd(pocc_pkg::RD_FAULT);
        temp_range_fault <= 1'b0;
        stall <= 1'b1;
        cmd(32'h1, 0);
        rd("no space", A_ST, 32'h12);
        stall <= 1'b0;
        smp(17'h01234, 0);
        cmd(32'h101, 1);
        cmd(32'h101, 0);
        bus(1'b1, A_RN, 32'h2);
        cmd(32'h3, 1);
        knd(pocc_pkg::RD_BINARY);
        chk("ext header", 32'(pocc_pkg::HDR_POS), 32'(last.bin_chars[47:40]));
        bus(1'b1, A_RN, 32'hE);
        cmd(32'h3, 1);
        chk("sgn header", 32'(pocc_pkg::HDR_STD), 32'(last.bin_chars[47:40]));
        bus(1'b1, A_RN, 32'h8);
        cmd(32'h1, 1);
        chk("no header", 32'h1, 32'(last.hdr_removed));
        $display("single reading test done");
    endtask : t_single
    task automatic t_cont();
        bus(1'b1, A_RN, 32'h1);
        cmd(32'h2, 1);
        smp(17'h01234, 0);
        smp(17'h01235, 1);
        cmd(32'h1, 1);
        knd(pocc_pkg::RD_TEXT);
        smp(17'h01236, 1);
        cmd(32'h6, 0);
        cmd(32'h5, 0);
        smp(17'h01237, 0);
        bus(1'b1, pocc_pkg::ADDR_ANALOG, 32'h8);
        cmd(32'h2, 1);
        smp(17'h01238, 0);
        cmd(32'h5, 0);
        $display("continuous test done");
    endtask : t_cont
    task automatic t_wdog();
        int n;
        n = 0;
        bus(1'b1, pocc_pkg::ADDR_AVG, 32'h5);
        bus(1'b1, A_RN, 32'h10);
        rd("dog refused", A_RN, 32'h0);
        rd("dog error", A_ST, 32'h1);
        bus(1'b1, pocc_pkg::ADDR_AVG, 32'h0);
        bus(1'b1, A_RN, 32'h10);
        rd("dog on", A_RN, 32'h10);
        proc_alive <= 1'b0;
        while (sys_reset_req !== 1'b1 && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        proc_alive <= 1'b1;
        chk("dog fired", 32'h1, 32'(n < 40));
        rd("offset restored", A_OF, 32'h0);
        rd("run restored", A_RN, 32'h0);
        $display("watchdog test done");
    endtask : t_wdog
    initial
    begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_offset();
        t_single();
        t_cont();
        t_wdog();
        print_verdict();
    end
endmodule : pocc_command_control_tb_top

// ### pocc_host_model.sv
// host side sink: grants output space, counts readings and keeps the last one received
`timescale 1ns/1ps
module pocc_host_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic stall,
    input wire pocc_pkg::pocc_reading_type reading,
    output logic tx_space,
    output pocc_pkg::pocc_reading_type last,
    output int count
);
    assign tx_space = !stall;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            count <= 0;
        else if (reading.valid)
        begin
            count <= count + 1;
            last <= reading;
        end
    end
endmodule : pocc_host_model

// ### pocc_pkg.sv
// shared constants and carrier types for the pressure output command block
package pocc_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_OFFSET = 8'h00;
    localparam logic [7:0] ADDR_SPAN = 8'h04;
    localparam logic [7:0] ADDR_RUN = 8'h08;
    localparam logic [7:0] ADDR_AVG = 8'h0C;
    localparam logic [7:0] ADDR_ANALOG = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_COMMAND = 8'h18;
    localparam logic [7:0] ADDR_DATE = 8'h1C;
    localparam logic [7:0] ADDR_DEVNUM = 8'h20;

    // field positions
    localparam int OFS_BAD_BIT = 15;
    localparam int CMD_GROUP_BIT = 8;
    localparam int AN_SCALE_BIT = 0;
    localparam int AN_TEXT_OFF_BIT = 1;
    localparam int AN_CONT_TX_BIT = 2;
    localparam int AN_MULTIDROP_BIT = 3;
    localparam int DATE_BANG_BIT = 24;
    localparam int ST_CMD_ERR_BIT = 0;
    localparam int ST_TEMP_BIT = 1;
    localparam int ST_PARITY_BIT = 2;
    localparam int ST_MEMCK_BIT = 3;
    localparam int ST_NO_SPACE_BIT = 4;

    // values and limits
    localparam logic [6:0] OFFSET_MAX = 7'h63;
    localparam logic [6:0] SPAN_FULL = 7'h64;
    localparam logic [6:0] OFFSET_RESET = 7'h00;
    localparam logic [16:0] SIGNED_FULL_COUNTS = 17'h0EA60;
    localparam logic [7:0] HDR_STD = 8'h23;
    localparam logic [7:0] HDR_POS = 8'h7B;
    localparam logic [7:0] HDR_NEG = 8'h7D;
    localparam logic [7:0] CHAR_BASE = 8'h40;

    // watchdog stall time
    localparam int CLK_PERIOD_NS = 10;
    localparam int WDOG_TIME_MS = 50;
    localparam int WDOG_CYCLES = WDOG_TIME_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {FMT_EXTENDED, FMT_FIXED, FMT_REMOVED,
        FMT_SIGNED} pocc_fmt_type;

    typedef enum logic [2:0] {CMD_NONE, CMD_SINGLE_TEXT, CMD_CONT_TEXT,
        CMD_SINGLE_BIN, CMD_CONT_BIN, CMD_STOP, CMD_SUSPEND,
        CMD_INVALIDATE} pocc_cmd_type;

    typedef enum logic [1:0] {CONT_IDLE, CONT_TEXT, CONT_BIN} pocc_cont_type;

    typedef enum logic [1:0] {RD_TEXT, RD_NODATA, RD_FAULT,
        RD_BINARY} pocc_rd_kind_type;

    // run parameters; all zero is the all/no-checksum/extended/no-dog default
    typedef struct packed {
        logic wdog;
        pocc_fmt_type fmt;
        logic checksum;
        logic changes_only;
    } pocc_op_type;

    typedef struct packed {
        logic valid;
        logic sign;
        logic [16:0] magnitude;
    } pocc_sample_type;

    typedef struct packed {
        logic valid;
        pocc_rd_kind_type kind;
        logic hdr_removed;
        logic fixed_sign;
        logic four_digit;
        logic sign;
        logic [16:0] magnitude;
        logic [47:0] bin_chars;
    } pocc_reading_type;

    typedef struct packed {
        logic [6:0] low_pct;
        logic [6:0] span_pct;
    } pocc_analog_type;

endpackage : pocc_pkg
